// ---- inc/dsc_defines.vh ----
// constants for the deep-sleep clock gating control block
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

`define DSC_SYSCTL_BASE 32'h400fe000
`define DSC_BASE_MASK 32'hfffff000
`define DSC_OFF_MASK 32'h00000ffc

`define DSC_OFF_RUN_CLOCK_CONFIG 32'h00000060
`define DSC_OFF_RUN_GATE 32'h00000108
`define DSC_OFF_SLEEP_GATE 32'h00000118
`define DSC_OFF_DEEP_SLEEP_GATE 32'h00000128
`define DSC_OFF_FAULT_STATUS 32'h00000190
`define DSC_OFF_FAULT_MASK 32'h00000194

`define DSC_BIT_PORT_A 0
`define DSC_BIT_PORT_G 6
`define DSC_BIT_MAC 28
`define DSC_BIT_PHY 30
`define DSC_BIT_ACG 27

`define DSC_NUM_UNITS 9
`define DSC_UNIT_MAC 7
`define DSC_UNIT_PHY 8

`define DSC_GATE_WMASK 32'h5000007f
`define DSC_ACG_WMASK 32'h08000000
`define DSC_FAULT_WMASK 32'h000001ff

`define DSC_GATE_RESET 32'h00000000
`define DSC_ACG_RESET 1'b0
`define DSC_FAULT_RESET 9'h000

`endif

// ---- rtl/dsc_clk_gate.v ----
// glitch-free clock gate cell for one controlled unit
`timescale 1ns/1ps
`default_nettype none

module dsc_clk_gate (
  input wire clk_i,
  input wire sys_rst_i,
  input wire en_i,
  output wire gclk_o
);

  reg en_low_ff;

  // enable captured on the falling clock edge, so the and-gate never chops a high phase
  always @(negedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_low_ff <= 1'b0;
    end else begin
      en_low_ff <= en_i;
    end
  end

  assign gclk_o = clk_i & en_low_ff;

endmodule // dsc_clk_gate

`default_nettype wire

// ---- rtl/dsc_gate_ctrl.v ----
// deep-sleep clock gating control with run and sleep gating, wishbone registers
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.vh"

module dsc_gate_ctrl #(
  parameter NUM_UNITS = `DSC_NUM_UNITS
) (
  input wire clk_i,
  input wire sys_rst_i,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // power state from the processor, same clock domain
  input wire sleep_i,
  input wire deep_sleep_i,
  // one access request pulse per unit from the system bus decoder
  input wire [NUM_UNITS-1:0] unit_acc_i,
  output wire [NUM_UNITS-1:0] unit_acc_ok_o,
  output wire bus_fault_o,
  // gated clocks and their enables
  output wire [NUM_UNITS-1:0] unit_clk_o,
  output wire [NUM_UNITS-1:0] unit_clk_en_o,
  output wire irq_o
);

  reg [31:0] run_gate_reg_ff;
  reg [31:0] sleep_gate_reg_ff;
  reg [31:0] deep_sleep_gate_reg_ff;
  reg auto_clock_gating_select_ff;
  reg [NUM_UNITS-1:0] fault_status_ff;
  reg [NUM_UNITS-1:0] fault_mask_ff;
  reg [NUM_UNITS-1:0] clk_en_ff;
  reg [NUM_UNITS-1:0] acc_ok_ff;
  reg bus_fault_ff;
  reg irq_ff;
  reg ack_ff;
  reg [31:0] dat_ff;

  reg [31:0] nxt_dat;
  reg [31:0] active_gate;
  reg [NUM_UNITS-1:0] nxt_clk_en;
  reg [NUM_UNITS-1:0] nxt_status;

  wire [31:0] byte_mask;
  wire [31:0] offset;
  wire in_block;
  wire req;
  wire wr;
  wire [NUM_UNITS-1:0] fault_clr;
  wire [NUM_UNITS-1:0] fault_hit;

  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign in_block = ((wb_adr_i & `DSC_BASE_MASK) == `DSC_SYSCTL_BASE);
  assign offset = wb_adr_i & `DSC_OFF_MASK;
  // one ack per request; ack drops the cycle after it is given
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & in_block;

  // merge masked write data; reserved bits never stored
  function [31:0] wmerge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] bmask;
    input [31:0] fmask;
    begin
      wmerge = ((old_val & ~bmask) | (new_val & bmask)) & fmask;
    end
  endfunction

  // gating registers; writes land at the ack edge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_gate_reg_ff <= `DSC_GATE_RESET;
      sleep_gate_reg_ff <= `DSC_GATE_RESET;
      deep_sleep_gate_reg_ff <= `DSC_GATE_RESET;
      auto_clock_gating_select_ff <= `DSC_ACG_RESET;
    end else if (wr) begin
      if (offset == `DSC_OFF_RUN_GATE) begin
        run_gate_reg_ff <= wmerge(run_gate_reg_ff, wb_dat_i, byte_mask, `DSC_GATE_WMASK);
      end
      if (offset == `DSC_OFF_SLEEP_GATE) begin
        sleep_gate_reg_ff <= wmerge(sleep_gate_reg_ff, wb_dat_i, byte_mask, `DSC_GATE_WMASK);
      end
      if (offset == `DSC_OFF_DEEP_SLEEP_GATE) begin
        deep_sleep_gate_reg_ff <= wmerge(deep_sleep_gate_reg_ff, wb_dat_i, byte_mask,
                                         `DSC_GATE_WMASK);
      end
      if (offset == `DSC_OFF_RUN_CLOCK_CONFIG && wb_sel_i[3]) begin
        auto_clock_gating_select_ff <= wb_dat_i[`DSC_BIT_ACG];
      end
    end
  end

  // which register governs the clocks now
  always @* begin
    active_gate = run_gate_reg_ff;
    if (auto_clock_gating_select_ff) begin
      if (deep_sleep_i) begin
        active_gate = deep_sleep_gate_reg_ff;
      end else if (sleep_i) begin
        active_gate = sleep_gate_reg_ff;
      end
    end
  end

  // map register bits onto unit order: ports a..g, mac, phy
  always @* begin
    nxt_clk_en = {NUM_UNITS{1'b0}};
    nxt_clk_en[`DSC_BIT_PORT_G:`DSC_BIT_PORT_A] =
      active_gate[`DSC_BIT_PORT_G:`DSC_BIT_PORT_A];
    nxt_clk_en[`DSC_UNIT_MAC] = active_gate[`DSC_BIT_MAC];
    nxt_clk_en[`DSC_UNIT_PHY] = active_gate[`DSC_BIT_PHY];
  end

  // registered enable: takes effect one edge after the write edge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_en_ff <= {NUM_UNITS{1'b0}};
    end else begin
      clk_en_ff <= nxt_clk_en;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi = gi + 1) begin : g_gate
      dsc_clk_gate u_gate (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(clk_en_ff[gi]),
        .gclk_o(unit_clk_o[gi])
      );
    end
  endgenerate

  // unit access check against the current enable
  assign fault_hit = unit_acc_i & ~clk_en_ff;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_ok_ff <= {NUM_UNITS{1'b0}};
      bus_fault_ff <= 1'b0;
    end else begin
      acc_ok_ff <= unit_acc_i & clk_en_ff;
      bus_fault_ff <= |fault_hit;
    end
  end

  // fault status: write one to clear, a new fault in the same cycle wins
  assign fault_clr = (wr && offset == `DSC_OFF_FAULT_STATUS) ?
                     (wb_dat_i[NUM_UNITS-1:0] & byte_mask[NUM_UNITS-1:0]) :
                     {NUM_UNITS{1'b0}};

  always @* begin
    nxt_status = (fault_status_ff & ~fault_clr) | fault_hit;
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_status_ff <= `DSC_FAULT_RESET;
      fault_mask_ff <= `DSC_FAULT_RESET;
      irq_ff <= 1'b0;
    end else begin
      fault_status_ff <= nxt_status;
      if (wr && offset == `DSC_OFF_FAULT_MASK) begin
        fault_mask_ff <= (fault_mask_ff & ~byte_mask[NUM_UNITS-1:0]) |
                         (wb_dat_i[NUM_UNITS-1:0] & byte_mask[NUM_UNITS-1:0]);
      end
      irq_ff <= |(nxt_status & fault_mask_ff);
    end
  end

  // read mux; unmapped offsets and foreign bases read zero but still ack
  always @* begin
    nxt_dat = 32'h00000000;
    if (in_block && !wb_we_i) begin
      case (offset)
        `DSC_OFF_RUN_GATE: begin
          nxt_dat = run_gate_reg_ff;
        end
        `DSC_OFF_SLEEP_GATE: begin
          nxt_dat = sleep_gate_reg_ff;
        end
        `DSC_OFF_DEEP_SLEEP_GATE: begin
          nxt_dat = deep_sleep_gate_reg_ff & `DSC_GATE_WMASK;
        end
        `DSC_OFF_RUN_CLOCK_CONFIG: begin
          nxt_dat[`DSC_BIT_ACG] = auto_clock_gating_select_ff;
        end
        `DSC_OFF_FAULT_STATUS: begin
          nxt_dat[NUM_UNITS-1:0] = fault_status_ff;
        end
        `DSC_OFF_FAULT_MASK: begin
          nxt_dat[NUM_UNITS-1:0] = fault_mask_ff;
        end
        default: begin
          nxt_dat = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= nxt_dat;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign unit_acc_ok_o = acc_ok_ff;
  assign bus_fault_o = bus_fault_ff;
  assign unit_clk_en_o = clk_en_ff;
  assign irq_o = irq_ff;

endmodule // dsc_gate_ctrl

`default_nettype wire

// ---- verif/dsc_gate_ctrl_sva.sv ----
// assertions for the deep-sleep clock gating control block
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.vh"
module dsc_gate_ctrl_sva #(
  parameter NUM_UNITS = 9
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [NUM_UNITS-1:0] unit_acc_i,
  input wire [NUM_UNITS-1:0] unit_acc_ok_o,
  input wire bus_fault_o,
  input wire [NUM_UNITS-1:0] unit_clk_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire dg_rd = req & ~wb_we_i & (wb_adr_i == `DSC_SYSCTL_BASE + `DSC_OFF_DEEP_SLEEP_GATE);
  wire far_rd = req & ~wb_we_i & ((wb_adr_i & `DSC_BASE_MASK) != `DSC_SYSCTL_BASE);
  wire [NUM_UNITS-1:0] off_acc = unit_acc_i & ~unit_clk_en_o;
  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_gate_read_clean: assert property (dg_rd |=> (wb_dat_o & ~`DSC_GATE_WMASK) == 32'h0)
    else $error("reserved gate bits read nonzero");
  a_far_read_zero: assert property (far_rd |=> wb_dat_o == 32'h0)
    else $error("foreign page read nonzero");
  a_fault_when_off: assert property (|off_acc |=> bus_fault_o)
    else $error("no fault on unclocked unit");
  a_quiet_when_on: assert property (!(|off_acc) |=> !bus_fault_o)
    else $error("fault without unclocked access");
  a_ok_when_on: assert property (1'b1 |=> unit_acc_ok_o == $past(unit_acc_i & unit_clk_en_o))
    else $error("access ok mismatch");
  cover property (wb_ack_o && wb_we_i);
  cover property (bus_fault_o);
  cover property (|unit_acc_ok_o);
endmodule // dsc_gate_ctrl_sva
bind dsc_gate_ctrl dsc_gate_ctrl_sva #(.NUM_UNITS(NUM_UNITS)) i_sva (.*);
`default_nettype wire

// ---- verif/tb_dsc_gate_ctrl.sv ----
// self-checking bench for the deep-sleep clock gating control block
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.vh"
module tb_dsc_gate_ctrl;
  localparam logic [31:0] B = `DSC_SYSCTL_BASE;
  localparam logic [31:0] DG = B + `DSC_OFF_DEEP_SLEEP_GATE;
  localparam logic [31:0] ST = B + `DSC_OFF_FAULT_STATUS;
  localparam logic [31:0] RG = 32'h10000001;
  logic clk_i = 0, sys_rst_i = 1, cyc = 0, we = 0, slp = 0, dsl = 0;
  logic [3:0] sel = 4'hf;
  logic [8:0] acc = 0;
  logic [31:0] adr = 0, wd = 0, rd, v;
  wire [31:0] dat;
  wire ack, flt, irq;
  wire [8:0] ok, en, gclk;
  int n_errors = 0, tests_run = 0;
  initial forever #4 clk_i = ~clk_i;
  dsc_gate_ctrl i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .sleep_i(slp), .deep_sleep_i(dsl), .unit_acc_i(acc),
    .unit_acc_ok_o(ok), .bus_fault_o(flt), .unit_clk_o(gclk), .unit_clk_en_o(en), .irq_o(irq));
  function automatic logic [31:0] units(input logic [31:0] g);
    return {23'h0, g[30], g[28], g[6:0]};
  endfunction
  task tally_and_finish();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // holds the request until ack is sampled, data taken at that edge
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wd <= d;
    do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 20);
    rd = dat;
    cyc <= 0; we <= 0;
    if (i >= 20) begin n_errors++; tally_and_finish(); end
  endtask
  task probe(input logic [8:0] u, input logic [31:0] e);
    @(posedge clk_i) acc <= u;
    @(posedge clk_i) acc <= 0;
    @(negedge clk_i);
    chk("unit ok", 32'(ok), 32'(u) & e);
    chk("bus fault", 32'(flt), 32'(|(u & ~e[8:0])));
  endtask
  task settle(input logic [31:0] e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) chk("enable", 32'(en), e);
    chk("gated clock low", 32'(gclk), 32'h0);
    // high phase: a gated clock runs only where its enable is set
    @(posedge clk_i);
    #2;
    chk("gated clock high", 32'(gclk), e);
  endtask
  initial begin
    v = $urandom(32'h8835);
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 0;
    wb(0, DG, 0);
    chk("gate reset", rd, `DSC_GATE_RESET);
    chk("enable reset", 32'(en), 32'h0);
    probe(9'h1ff, 0);
    $display("test reset done");
    wb(1, B + `DSC_OFF_RUN_CLOCK_CONFIG, `DSC_ACG_WMASK);
    dsl <= 1;
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'hffffffff : $urandom();
      wb(1, DG, v);
      wb(0, DG, 0);
      chk("gate readback", rd, v & `DSC_GATE_WMASK);
      settle(units(v));
      probe(9'($urandom()), units(v));
    end
    sel <= 4'h1;
    wb(1, DG, 32'h0);
    sel <= 4'hf;
    wb(1, 32'h20000128, 32'hffffffff);
    wb(0, B + 32'h00000ffc, 0);
    chk("unmapped", rd, 32'h0);
    wb(0, DG, 0);
    chk("byte select", rd, v & `DSC_GATE_WMASK & 32'hffffff00);
    $display("test deep gate done");
    wb(1, B + `DSC_OFF_RUN_GATE, RG);
    wb(1, B + `DSC_OFF_SLEEP_GATE, 32'h40000040);
    dsl <= 0;
    slp <= 1;
    settle(units(32'h40000040));
    slp <= 0;
    settle(units(RG));
    wb(1, B + `DSC_OFF_RUN_CLOCK_CONFIG, 0);
    dsl <= 1;
    settle(units(RG));
    $display("test modes done");
    wb(1, ST, 32'h1ff);
    wb(1, ST + 32'h4, 32'h002);
    probe(9'h004, units(RG));
    repeat (3) @(negedge clk_i);
    chk("irq masked", 32'(irq), 32'h0);
    probe(9'h002, units(RG));
    repeat (3) @(negedge clk_i);
    chk("irq raised", 32'(irq), 32'h1);
    wb(0, ST, 0);
    chk("fault status", rd, 32'h006);
    wb(1, ST, 32'h002);
    repeat (3) @(negedge clk_i);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule // tb_dsc_gate_ctrl
`default_nettype wire
